/* File: inc/drs_pkg.sv */
// Purpose: Shared constants for the refresh command link and both of its ends
// Assumes: 10 MHz ref_clk_i, one command per clock edge, eight banks per channel
// Notes:   Command codes other than refresh are local choices of this block
//
// What this block does
// - Refresh decoded: select low, CA0/CA1 low, CA2/CKE high
// - Scope bit low per-bank, high all-bank
// - Per-bank refreshes ascend round robin, wrapping
// - Bank counter zeroed on reset, self refresh exit, all-bank
// - Per-bank refresh uses precharge bank field
// - Only idle banks may be refreshed
// - Controller tracks its per-bank refresh target
// - Per-bank refresh waits all prior separations
// - Refreshing bank blocked, other banks stay usable
// - Refreshed banks end idle
// - After per-bank refresh honour its separations
// - All-bank refresh needs idle banks, separations
// - After all-bank refresh wait its cycle time
// - Average one all-bank refresh per scaled interval
// - At most eight postponed, nine-interval gap
// - At most eight pulled in count
// - Sixteen all-bank refreshes per two intervals
// - Per-bank limits sixty-four and one twenty-eight
// - Legacy rate codes, multipliers, limit eight
// - Modified limits two at 4x, four at 2x
// - Slowing transition drains postponed, clears pulled-in
// - Reported or faster rate; 010 forbids 4x
package drs_pkg;

	localparam int BANKS         = 8;
	localparam int BANK_W        = 3;
	localparam int CA_W          = 10;
	localparam int CA_SCOPE_BIT  = 4;
	localparam int CA_BANK_LSB   = 7;
	localparam int TMR_W         = 4;
	localparam int DEBT_W        = 9;
	localparam int IVL_W         = 16;

	// Command field ca[2:0] = {CA2, CA1, CA0}
	localparam logic [2:0] OP_REF = 3'h4;
	localparam logic [2:0] OP_ACT = 3'h2;
	localparam logic [2:0] OP_PRE = 3'h3;

	// Reported refresh rate codes
	localparam logic [2:0] RATE_LOW  = 3'h0;
	localparam logic [2:0] RATE_4X   = 3'h1;
	localparam logic [2:0] RATE_2X   = 3'h2;
	localparam logic [2:0] RATE_1X   = 3'h3;
	localparam logic [2:0] RATE_Q1   = 3'h5;
	localparam logic [2:0] RATE_Q2   = 3'h6;
	localparam logic [2:0] RATE_HIGH = 3'h7;

	localparam logic [6:0] LIM_LEGACY  = 7'h08;
	localparam logic [6:0] LIM_MOD_4X  = 7'h02;
	localparam logic [6:0] LIM_MOD_2X  = 7'h04;
	localparam logic [7:0] WIN_AB_MAX  = 8'h10;
	localparam logic [7:0] WIN_PB_MAX  = 8'h80;
	localparam int         PB_PER_AB   = 8;

	localparam int CLK_PERIOD_NS = 100;
	localparam int T_RFCAB_NS    = 180;
	localparam int T_RFCPB_NS    = 90;
	localparam int T_RP_NS       = 18;
	localparam int T_RRD_NS      = 10;
	localparam int T_REFI_NS     = 3900;

	localparam logic [TMR_W-1:0] RFCAB_CYC =
		TMR_W'((T_RFCAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] RFCPB_CYC =
		TMR_W'((T_RFCPB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] RP_CYC =
		TMR_W'((T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] RRD_CYC =
		TMR_W'((T_RRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int REFI_CYC = T_REFI_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0]
	{
		MODE_RUN  = 2'b00,
		MODE_SREF = 2'b01
	} drs_mode_type;

endpackage : drs_pkg

/* File: inc/drs_if.sv */
// Purpose: Command link between the refresh controller and the device end
// Assumes: Both ends share ref_clk_i
// Notes:   Controller drives every signal
`timescale 1ns/1ps
interface drs_if;
	import drs_pkg::*;

	logic                cs_n;
	logic                cke;
	logic [CA_W-1:0]     ca;

	modport ctrl (output cs_n, output cke, output ca);
	modport dev  (input cs_n, input cke, input ca);

endinterface : drs_if

/* File: core/drs_timer.sv */
// Purpose: Down counter marking a separation window as busy
// Assumes: Load value counts whole clock cycles
// Notes:   busy_o is high for exactly value_i cycles after the load edge
`timescale 1ns/1ps
module drs_timer
#(
	parameter int W = 4
)
(
	input  wire logic         ref_clk_i,
	input  wire logic         reset_n_i,
	input  wire logic         load_i,
	input  wire logic [W-1:0] value_i,
	output logic              busy_o
);

	logic [W-1:0] count_q;

	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			count_q <= '0;
			busy_o  <= 1'b0;
		end
		else if (load_i)
		begin
			count_q <= value_i;
			busy_o  <= (value_i != '0);
		end
		else if (count_q != '0)
		begin
			count_q <= count_q - 1'b1;
			busy_o  <= (count_q > W'(1));
		end
	end

endmodule : drs_timer

/* File: core/drs_device.sv */
// Purpose: Device end: decodes refresh traffic and tracks bank refresh state
// Assumes: Link comes from logic on the same clock, so no synchroniser
// Notes:   Error flags are sticky until reset
`timescale 1ns/1ps
module drs_device
(
	input  wire logic                        ref_clk_i,
	input  wire logic                        reset_n_i,
	drs_if.dev                               link,
	output logic [drs_pkg::BANKS-1:0]        bank_open_o,
	output logic [drs_pkg::BANKS-1:0]        bank_refreshing_o,
	output logic [drs_pkg::BANK_W-1:0]       pb_bank_o,
	output logic                             in_sref_o,
	output logic                             order_err_o,
	output logic                             busy_err_o
);
	import drs_pkg::*;

	drs_mode_type            mode_q;
	logic                    cke_q;
	logic [BANKS-1:0]        open_q;
	logic [BANK_W-1:0]       pb_q;
	logic [BANKS-1:0]        refr;

	wire [2:0]        op       = link.ca[2:0];
	wire [BANK_W-1:0] bank     = link.ca[CA_BANK_LSB +: BANK_W];
	wire              sel      = !link.cs_n && (mode_q == MODE_RUN);
	wire              is_ref   = sel && link.cke && (op == OP_REF);
	wire              ref_ab   = is_ref && link.ca[CA_SCOPE_BIT];
	wire              ref_pb   = is_ref && !link.ca[CA_SCOPE_BIT];
	wire              is_act   = sel && link.cke && (op == OP_ACT);
	wire              is_pre   = sel && link.cke && (op == OP_PRE);
	wire              sref_in  = sel && !link.cke && cke_q && (op == OP_REF);
	wire              sref_out = (mode_q == MODE_SREF) && link.cke;
	wire              pb_wrap  = (pb_q == BANK_W'(BANKS - 1));
	wire              bad_ord  = ref_pb && (bank != pb_q);
	wire              bad_busy = (ref_pb && (open_q[bank] || refr[bank]))
		|| (ref_ab && ((open_q != '0) || (refr != '0)))
		|| (is_act && refr[bank]);

	genvar gi;
	generate
		for (gi = 0; gi < BANKS; gi++)
		begin : g_bank
			wire hit = (ref_pb && (bank == BANK_W'(gi))) || ref_ab;
			drs_timer #(.W(TMR_W)) u_rfc
			(
				.ref_clk_i (ref_clk_i),
				.reset_n_i (reset_n_i),
				.load_i    (hit),
				.value_i   (ref_ab ? RFCAB_CYC : RFCPB_CYC),
				.busy_o    (refr[gi])
			);
		end
	endgenerate

	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			mode_q <= MODE_RUN;
			cke_q  <= 1'b0;
			open_q <= '0;
			pb_q   <= '0;
		end
		else
		begin
			cke_q <= link.cke;
			if (sref_in)
				mode_q <= MODE_SREF;
			else if (sref_out)
				mode_q <= MODE_RUN;
			if (ref_ab || sref_out)
				pb_q <= '0;
			else if (ref_pb)
				pb_q <= pb_wrap ? '0 : pb_q + 1'b1;
			if (ref_ab || (is_pre && link.ca[CA_SCOPE_BIT]))
				open_q <= '0;
			else if (ref_pb || is_pre)
				open_q[bank] <= 1'b0;
			else if (is_act && !refr[bank])
				open_q[bank] <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			bank_open_o       <= '0;
			bank_refreshing_o <= '0;
			pb_bank_o         <= '0;
			in_sref_o         <= 1'b0;
			order_err_o       <= 1'b0;
			busy_err_o        <= 1'b0;
		end
		else
		begin
			bank_open_o       <= open_q;
			bank_refreshing_o <= refr;
			pb_bank_o         <= pb_q;
			in_sref_o         <= (mode_q == MODE_SREF);
			order_err_o       <= order_err_o || bad_ord;
			busy_err_o        <= busy_err_o || bad_busy;
		end
	end

endmodule : drs_device

/* File: core/drs_controller.sv */
// Purpose: Controller end: schedules refresh, activate and precharge commands
// Assumes: User requests held until their done pulse; one command per cycle
// Notes:   Refresh debt is positive when postponed, negative when pulled in
`timescale 1ns/1ps
module drs_controller
#(
	parameter int REFI_CYCLES = drs_pkg::REFI_CYC
)
(
	input  wire logic                          ref_clk_i,
	input  wire logic                          reset_n_i,
	drs_if.ctrl                                link,
	input  wire logic                          act_req_i,
	input  wire logic [drs_pkg::BANK_W-1:0]    act_bank_i,
	input  wire logic                          pre_req_i,
	input  wire logic [drs_pkg::BANK_W-1:0]    pre_bank_i,
	input  wire logic                          ref_allow_i,
	input  wire logic                          pull_in_i,
	input  wire logic                          pb_mode_i,
	input  wire logic                          modified_i,
	input  wire logic [2:0]                    rate_rep_i,
	input  wire logic [2:0]                    rate_pick_i,
	input  wire logic                          sref_req_i,
	output logic                               act_done_o,
	output logic                               pre_done_o,
	output logic                               ref_done_o,
	output logic                               forced_o,
	output logic signed [drs_pkg::DEBT_W-1:0]  debt_o,
	output logic [drs_pkg::BANK_W-1:0]         pb_bank_o,
	output logic [drs_pkg::BANKS-1:0]          bank_open_o,
	output logic                               in_sref_o
);
	import drs_pkg::*;

	drs_mode_type              mode_q;
	logic                      cs_n_q;
	logic                      cke_q;
	logic [CA_W-1:0]           ca_q;
	logic                      cs_n_d;
	logic                      cke_d;
	logic [CA_W-1:0]           ca_d;
	logic [BANKS-1:0]          open_q;
	logic [BANK_W-1:0]         pb_q;
	logic signed [DEBT_W-1:0]  debt_q;
	logic signed [DEBT_W-1:0]  debt_d;
	logic [IVL_W-1:0]          icnt_q;
	logic [2:0]                rate_q;
	logic                      half_q;
	logic [7:0]                win_q;
	logic [BANKS-1:0]          bank_busy;
	logic                      rfcab_busy;
	logic                      rfcpb_busy;
	logic                      rrd_busy;

	function automatic logic [CA_W-1:0] ca_word(logic [2:0] op, logic scope,
		logic [BANK_W-1:0] bank);
		logic [CA_W-1:0] w;
		w = '0;
		w[2:0] = op;
		w[CA_SCOPE_BIT] = scope;
		w[CA_BANK_LSB +: BANK_W] = bank;
		return w;
	endfunction : ca_word

	// Effective rate: reported limit codes clamp, a faster pick is taken
	wire [2:0] rep_c = (rate_rep_i == RATE_LOW) ? RATE_4X :
		(rate_rep_i == RATE_HIGH) ? RATE_Q2 : rate_rep_i;
	wire [2:0] rate_used = ((rate_pick_i > rep_c) && (rate_pick_i != RATE_HIGH))
		? rate_pick_i : rep_c;
	wire [2:0] rshift = (rate_used == RATE_Q2) ? 3'h4 : rate_used - 3'h1;
	wire [IVL_W-1:0] base4 = IVL_W'(REFI_CYCLES * 4);
	wire [IVL_W-1:0] interval = base4 >> rshift;
	wire tick = (mode_q == MODE_RUN) && ((icnt_q + 16'h1) >= interval);

	wire [6:0] lim_ab = (modified_i && (rate_used == RATE_4X)) ? LIM_MOD_4X :
		(modified_i && (rate_used == RATE_2X)) ? LIM_MOD_2X : LIM_LEGACY;
	wire [6:0] lim = pb_mode_i ? (lim_ab << 3) : lim_ab;
	wire signed [DEBT_W-1:0] lim_s = $signed({2'b00, lim});
	wire into_slow = (rate_used != rate_q)
		&& ((rate_used == RATE_4X) || (rate_used == RATE_2X));

	wire run      = (mode_q == MODE_RUN);
	wire all_idle = (open_q == '0);
	wire signed [DEBT_W-1:0] step_s = pb_mode_i ? DEBT_W'(PB_PER_AB) : DEBT_W'(1);
	// Forced one tick early in per-bank mode so a tick never overshoots the limit
	wire forced   = run && (debt_q > lim_s - step_s);
	wire pull_ok  = debt_q > -lim_s;
	wire win_ok   = win_q < (pb_mode_i ? WIN_PB_MAX : WIN_AB_MAX);
	wire ab_ok    = all_idle && (bank_busy == '0) && !rfcab_busy && !rfcpb_busy;
	wire pb_ok    = !open_q[pb_q] && !bank_busy[pb_q] && !rfcab_busy
		&& !rfcpb_busy && !rrd_busy;
	wire ref_ok   = run && win_ok && (pb_mode_i ? pb_ok : ab_ok);
	wire want_ref = forced
		|| (ref_allow_i && ((debt_q > 0) || (pull_in_i && pull_ok)));
	wire do_ref   = want_ref && ref_ok;
	wire do_pall  = forced && !do_ref && !rfcab_busy
		&& (pb_mode_i ? open_q[pb_q] : !all_idle);
	wire do_sref  = run && sref_req_i && !forced && ab_ok && !do_ref;
	wire do_sx    = !run && !sref_req_i;
	wire do_act   = run && act_req_i && !forced && !do_ref && !do_sref
		&& !open_q[act_bank_i] && !bank_busy[act_bank_i]
		&& !rfcab_busy && !rrd_busy;
	wire do_pre   = run && pre_req_i && !do_ref && !do_pall && !do_sref
		&& !do_act && open_q[pre_bank_i];
	wire ref_ab   = do_ref && !pb_mode_i;
	wire ref_pb   = do_ref && pb_mode_i;
	wire pb_wrap  = (pb_q == BANK_W'(BANKS - 1));

	genvar gi;
	generate
		for (gi = 0; gi < BANKS; gi++)
		begin : g_bank
			wire hit_pb  = ref_pb && (pb_q == BANK_W'(gi));
			wire hit_pre = do_pall || (do_pre && (pre_bank_i == BANK_W'(gi)));
			drs_timer #(.W(TMR_W)) u_bank
			(
				.ref_clk_i (ref_clk_i),
				.reset_n_i (reset_n_i),
				.load_i    (hit_pb || hit_pre),
				.value_i   (hit_pb ? RFCPB_CYC : RP_CYC),
				.busy_o    (bank_busy[gi])
			);
		end
	endgenerate

	drs_timer #(.W(TMR_W)) u_rfcab
	(
		.ref_clk_i (ref_clk_i),
		.reset_n_i (reset_n_i),
		.load_i    (ref_ab),
		.value_i   (RFCAB_CYC),
		.busy_o    (rfcab_busy)
	);

	drs_timer #(.W(TMR_W)) u_rfcpb
	(
		.ref_clk_i (ref_clk_i),
		.reset_n_i (reset_n_i),
		.load_i    (ref_pb),
		.value_i   (RFCPB_CYC),
		.busy_o    (rfcpb_busy)
	);

	drs_timer #(.W(TMR_W)) u_rrd
	(
		.ref_clk_i (ref_clk_i),
		.reset_n_i (reset_n_i),
		.load_i    (do_act || ref_pb),
		.value_i   (RRD_CYC),
		.busy_o    (rrd_busy)
	);

	always_comb
	begin
		debt_d = debt_q;
		if (tick)
			debt_d = debt_d + (pb_mode_i ? DEBT_W'(PB_PER_AB) : DEBT_W'(1));
		if (do_ref)
			debt_d = debt_d - DEBT_W'(1);
		if (into_slow && (debt_d < 0))
			debt_d = '0;
	end

	always_comb
	begin
		cs_n_d = 1'b1;
		cke_d  = cke_q;
		ca_d   = ca_q;
		if (do_ref)
		begin
			cs_n_d = 1'b0;
			ca_d   = ca_word(OP_REF, !pb_mode_i, pb_q);
		end
		else if (do_pall)
		begin
			cs_n_d = 1'b0;
			ca_d   = ca_word(OP_PRE, !pb_mode_i, pb_q);
		end
		else if (do_sref)
		begin
			cs_n_d = 1'b0;
			cke_d  = 1'b0;
			ca_d   = ca_word(OP_REF, 1'b1, '0);
		end
		else if (do_sx)
			cke_d = 1'b1;
		else if (do_act)
		begin
			cs_n_d = 1'b0;
			ca_d   = ca_word(OP_ACT, 1'b0, act_bank_i);
		end
		else if (do_pre)
		begin
			cs_n_d = 1'b0;
			ca_d   = ca_word(OP_PRE, 1'b0, pre_bank_i);
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			mode_q <= MODE_RUN;
			cs_n_q <= 1'b1;
			cke_q  <= 1'b1;
			ca_q   <= '0;
			open_q <= '0;
			pb_q   <= '0;
			debt_q <= '0;
			icnt_q <= '0;
			rate_q <= RATE_1X;
			half_q <= 1'b0;
			win_q  <= '0;
		end
		else
		begin
			cs_n_q <= cs_n_d;
			cke_q  <= cke_d;
			ca_q   <= ca_d;
			debt_q <= debt_d;
			rate_q <= rate_used;
			icnt_q <= tick ? '0 : (run ? icnt_q + 16'h1 : icnt_q);
			if (do_sref)
				mode_q <= MODE_SREF;
			else if (do_sx)
				mode_q <= MODE_RUN;
			if (ref_ab || do_sx)
				pb_q <= '0;
			else if (ref_pb)
				pb_q <= pb_wrap ? '0 : pb_q + 1'b1;
			if (do_pall && !pb_mode_i)
				open_q <= '0;
			else if (do_pall)
				open_q[pb_q] <= 1'b0;
			else if (do_act)
				open_q[act_bank_i] <= 1'b1;
			else if (do_pre)
				open_q[pre_bank_i] <= 1'b0;
			if (tick)
				half_q <= !half_q;
			if (tick && half_q)
				win_q <= do_ref ? 8'h01 : 8'h00;
			else if (do_ref)
				win_q <= win_q + 8'h01;
		end
	end

	assign link.cs_n = cs_n_q;
	assign link.cke  = cke_q;
	assign link.ca   = ca_q;

	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			act_done_o  <= 1'b0;
			pre_done_o  <= 1'b0;
			ref_done_o  <= 1'b0;
			forced_o    <= 1'b0;
			debt_o      <= '0;
			pb_bank_o   <= '0;
			bank_open_o <= '0;
			in_sref_o   <= 1'b0;
		end
		else
		begin
			act_done_o  <= do_act;
			pre_done_o  <= do_pre;
			ref_done_o  <= do_ref;
			forced_o    <= forced;
			debt_o      <= debt_q;
			pb_bank_o   <= pb_q;
			bank_open_o <= open_q;
			in_sref_o   <= !run;
		end
	end

endmodule : drs_controller

/* File: bench/drs_monitor.sv */
// Purpose: Link checker for the refresh command channel
// Assumes: One clock; sees only the link wires
// Notes:   Tracks open banks, the next per-bank target and the refresh gap
`timescale 1ns/1ps
module drs_monitor
#(
	parameter int REFI_CYCLES = drs_pkg::REFI_CYC
)
(
	input wire logic                     ref_clk_i,
	input wire logic                     reset_n_i,
	input wire logic                     cs_n,
	input wire logic                     cke,
	input wire logic [drs_pkg::CA_W-1:0] ca
);
	import drs_pkg::*;
	localparam int GAP_MAX = 36 * REFI_CYCLES + 16;
	wire               is_cmd = !cs_n && cke;
	wire               is_ref = is_cmd && ca[2:0] == OP_REF;
	wire               is_ab  = is_ref && ca[CA_SCOPE_BIT];
	wire               is_pb  = is_ref && !ca[CA_SCOPE_BIT];
	wire               is_act = is_cmd && ca[2:0] == OP_ACT;
	wire               is_pre = is_cmd && ca[2:0] == OP_PRE;
	wire [BANK_W-1:0]  bank   = ca[CA_BANK_LSB +: BANK_W];
	wire [BANKS-1:0]   hit    = BANKS'(1) << bank;
	logic [BANKS-1:0]  open_q;
	logic [BANKS-1:0]  open_d;
	logic [BANK_W-1:0] next_q;
	logic [BANK_W-1:0] next_d;
	logic              sync_q;
	logic              sync_d;
	logic              cke_q;
	logic [15:0]       gap_q;
	logic [15:0]       gap_d;
	// Bank count restarts on all-bank refresh and self refresh exit
	wire               resync = is_ab || (cke && !cke_q);
	assign sync_d = resync || (sync_q && !is_pb);
	assign next_d = resync ? '0 : next_q + BANK_W'(is_pb);
	assign open_d = (is_ab || (is_pre && ca[CA_SCOPE_BIT])) ? '0 :
		is_pre ? (open_q & ~hit) : is_act ? (open_q | hit) : open_q;
	assign gap_d = is_ref ? '0 : gap_q + 16'(cke);
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
		if (!reset_n_i)
		begin
			open_q <= '0;
			next_q <= '0;
			sync_q <= 1'b1;
			cke_q  <= 1'b1;
			gap_q  <= '0;
		end
		else
		begin
			open_q <= open_d;
			next_q <= next_d;
			sync_q <= sync_d;
			cke_q  <= cke;
			gap_q  <= gap_d;
		end
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!reset_n_i);
	sequence s_pb_pair;
		is_pb ##2 is_pb;
	endsequence
	sequence s_in_sref;
		!cke ##1 !cke;
	endsequence
	a_pb_round_robin: assert property (is_pb |-> bank == next_q)
		else $error("per-bank refresh out of order");
	a_pb_resync_zero: assert property (is_pb && sync_q |-> bank == '0)
		else $error("per-bank refresh not at bank zero after resync");
	a_pb_step_one: assert property (s_pb_pair |-> bank == $past(bank, 2) + 3'h1)
		else $error("back to back per-bank refresh did not step by one");
	a_ab_rfc_gap: assert property (is_ab |=> !(is_ref || is_act))
		else $error("command inside all-bank refresh cycle");
	a_ab_all_idle: assert property (is_ab |-> open_q == '0)
		else $error("all-bank refresh with a bank open");
	a_pb_bank_idle: assert property (is_pb |-> !open_q[bank])
		else $error("per-bank refresh to an open bank");
	a_gap_bounded: assert property (gap_q <= 16'(GAP_MAX))
		else $error("refresh gap too long");
	a_sref_quiet: assert property (s_in_sref |-> cs_n)
		else $error("command issued in self refresh");
endmodule : drs_monitor

/* File: bench/tb_top.sv */
// Purpose: Self-checking bench joining controller and device ends
// Assumes: Short refresh interval parameter; 10 MHz clock
// Notes:   Link commands checked against notes queued by the driver
`timescale 1ns/1ps
module tb_top;
	import drs_pkg::*;
	localparam int REFI = 16;
	logic ref_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic act_req, pre_req, ref_allow, pull_in, pb_mode, modified, sref_req;
	logic [BANK_W-1:0] act_bank, pre_bank, c_pb, d_pb, c_pb_q;
	logic [2:0] rate_rep, rate_pick;
	logic act_done, pre_done, ref_done, forced, c_sref, d_sref, order_err, busy_err;
	logic signed [DEBT_W-1:0] debt, lo_v, hi_v;
	logic [BANKS-1:0] c_open, d_open, d_rfsh, c_open_q;
	logic [BANK_W-1:0] act_q[$], pb_q[$];
	logic [4:0] p1, p2;
	int miscompares = 0, n_compared = 0, seed = 49379, cur_lim = 0;
	drs_if link();
	wire cmd = reset_n_i && link.cs_n === 1'b0 && link.cke === 1'b1;
	wire [BANK_W-1:0] lbank = link.ca[CA_BANK_LSB +: BANK_W];
	always #50 ref_clk_i = ~ref_clk_i;
	drs_controller #(.REFI_CYCLES(REFI)) drs_controller_i
	(
		.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .link(link), .act_req_i(act_req),
		.act_bank_i(act_bank), .pre_req_i(pre_req), .pre_bank_i(pre_bank),
		.ref_allow_i(ref_allow), .pull_in_i(pull_in), .pb_mode_i(pb_mode),
		.modified_i(modified), .rate_rep_i(rate_rep), .rate_pick_i(rate_pick),
		.sref_req_i(sref_req), .act_done_o(act_done), .pre_done_o(pre_done),
		.ref_done_o(ref_done), .forced_o(forced), .debt_o(debt), .pb_bank_o(c_pb),
		.bank_open_o(c_open), .in_sref_o(c_sref)
	);
	drs_device drs_device_i
	(
		.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .link(link), .bank_open_o(d_open),
		.bank_refreshing_o(d_rfsh), .pb_bank_o(d_pb), .in_sref_o(d_sref),
		.order_err_o(order_err), .busy_err_o(busy_err)
	);
	drs_monitor #(.REFI_CYCLES(REFI)) drs_monitor_i
	(
		.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .cs_n(link.cs_n), .cke(link.cke),
		.ca(link.ca)
	);
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check
	task automatic test_done;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done
	task automatic span(input int n);
		lo_v = debt;
		hi_v = debt;
		repeat (n)
		begin
			@(negedge ref_clk_i);
			lo_v = (debt < lo_v) ? debt : lo_v;
			hi_v = (debt > hi_v) ? debt : hi_v;
		end
	endtask : span
	task automatic traffic(input int n);
		logic [BANK_W-1:0] b;
		repeat (n)
		begin
			b = BANK_W'($random(seed));
			@(posedge ref_clk_i);
			if (c_open[b] === 1'b1)
			begin
				pre_req <= 1'b1;
				pre_bank <= b;
				for (int k = 0; k < 500 && pre_done !== 1'b1 && c_open[b] === 1'b1; k++)
					@(posedge ref_clk_i);
				pre_req <= 1'b0;
			end
			else
			begin
				act_q.push_back(b);
				act_req <= 1'b1;
				act_bank <= b;
				for (int k = 0; k < 500 && act_done !== 1'b1; k++)
					@(posedge ref_clk_i);
				act_req <= 1'b0;
				check("activate done", 1'b1, act_done);
			end
		end
		$display("test traffic done");
	endtask : traffic
	task automatic limits(input logic m, input logic [2:0] rep, input logic [2:0] pick,
		input int lim);
		cur_lim = 0;
		@(posedge ref_clk_i);
		pull_in <= 1'b0;
		ref_allow <= 1'b1;
		modified <= m;
		rate_rep <= rep;
		rate_pick <= pick;
		repeat (3) @(negedge ref_clk_i);
		if (rep == RATE_4X || rep == RATE_2X)
			check("pulled-in cleared", 1'b1, debt >= 0);
		cur_lim = lim;
		@(posedge ref_clk_i);
		ref_allow <= 1'b0;
		for (int k = 0; k < 3000 && forced !== 1'b1; k++)
			@(posedge ref_clk_i);
		span(140);
		check("postponed peak", lim, hi_v);
		@(posedge ref_clk_i);
		ref_allow <= 1'b1;
		pull_in <= 1'b1;
		repeat (400) @(negedge ref_clk_i);
		span(60);
		check("pull-in floor", -lim, lo_v);
		$display("test limits rate %0h done", rep);
	endtask : limits
	always @(negedge ref_clk_i)
	begin
		// Device view trails the controller view by one cycle
		if (reset_n_i)
		begin
			check("refresh done", cmd && link.ca[2:0] == OP_REF, ref_done);
			check("bank count agree", c_pb_q, d_pb);
			check("open banks agree", c_open_q, d_open);
		end
		c_pb_q = c_pb;
		c_open_q = c_open;
		if (p2[3])
			check("device next bank", p2[2:0], d_pb);
		if (p2[4])
			check("all banks refreshing", 8'hFF, d_rfsh);
		p2 = p1;
		p1 = '0;
		if (cmd && link.ca[2:0] == OP_ACT && act_q.size() > 0)
			check("activate bank", act_q.pop_front(), lbank);
		if (cmd && link.ca[2:0] == OP_REF)
		begin
			check("refresh while busy", 1'b0, busy_err);
			p1 = {link.ca[CA_SCOPE_BIT], 1'b1, link.ca[CA_SCOPE_BIT] ? 3'h0 : lbank + 3'h1};
			if (!link.ca[CA_SCOPE_BIT])
				check("per-bank target", pb_q.size() ? pb_q.pop_front() : 16'hFFFF, lbank);
		end
		if (reset_n_i && cur_lim > 0)
			check("pull-in bound", 1'b1, debt >= -cur_lim);
	end
	initial
	begin
		repeat (60000) @(posedge ref_clk_i);
		miscompares++;
		$display("watchdog expired");
		test_done();
	end
	initial
	begin
		{act_req, pre_req, ref_allow, pull_in, pb_mode, modified, sref_req} = '0;
		{act_bank, pre_bank, p1, p2, c_pb_q, c_open_q} = '0;
		rate_rep = RATE_1X;
		rate_pick = RATE_1X;
		repeat (4) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		@(negedge ref_clk_i);
		check("idle select", 1'b1, link.cs_n);
		check("device count at reset", 3'h0, d_pb);
		$display("test reset done");
		@(posedge ref_clk_i);
		ref_allow <= 1'b1;
		traffic(30);
		limits(0, RATE_1X, RATE_1X, 8);
		limits(1, RATE_4X, RATE_4X, 2);
		limits(0, 3'h4, 3'h4, 8);
		limits(1, RATE_2X, RATE_4X, 4);
		limits(0, RATE_Q1, RATE_Q1, 8);
		limits(0, RATE_4X, RATE_4X, 8);
		limits(0, RATE_Q2, RATE_Q2, 8);
		limits(0, RATE_2X, RATE_2X, 8);
		limits(0, RATE_LOW, RATE_LOW, 8);
		limits(1, RATE_HIGH, RATE_HIGH, 8);
		cur_lim = 0;
		@(posedge ref_clk_i);
		{pull_in, modified, ref_allow} <= 3'h0;
		{rate_rep, rate_pick} <= {RATE_1X, RATE_1X};
		for (int k = 0; k < 3000 && forced !== 1'b1; k++)
			@(posedge ref_clk_i);
		@(posedge ref_clk_i);
		modified <= 1'b1;
		{rate_rep, rate_pick} <= {RATE_4X, RATE_4X};
		hi_v = debt;
		repeat (15)
		begin
			repeat (2) @(negedge ref_clk_i);
			if (debt > 2)
				check("drain step", 1'b1, debt <= hi_v);
			hi_v = debt;
		end
		check("drained", 1'b1, debt <= 2);
		$display("test drain done");
		@(posedge ref_clk_i);
		{modified, ref_allow} <= 2'h1;
		for (int k = 0; k < 3000 && debt !== 0; k++)
			@(posedge ref_clk_i);
		for (int i = 0; i < 600; i++)
			pb_q.push_back(BANK_W'(i));
		pb_mode <= 1'b1;
		traffic(20);
		limits(0, RATE_4X, RATE_4X, 64);
		@(posedge ref_clk_i);
		pull_in <= 1'b0;
		sref_req <= 1'b1;
		for (int k = 0; k < 500 && c_sref !== 1'b1; k++)
			@(posedge ref_clk_i);
		repeat (2) @(negedge ref_clk_i);
		check("device self refresh", 1'b1, d_sref);
		hi_v = debt;
		repeat (50) @(negedge ref_clk_i);
		check("debt frozen", hi_v, debt);
		pb_q.delete();
		for (int i = 0; i < 600; i++)
			pb_q.push_back(BANK_W'(i));
		@(posedge ref_clk_i);
		sref_req <= 1'b0;
		for (int k = 0; k < 500 && c_sref !== 1'b0; k++)
			@(posedge ref_clk_i);
		repeat (2) @(negedge ref_clk_i);
		check("count after exit", 3'h0, d_pb);
		traffic(20);
		repeat (600) @(negedge ref_clk_i);
		check("order error", 1'b0, order_err);
		check("busy error", 1'b0, busy_err);
		$display("test self refresh done");
		test_done();
	end
endmodule : tb_top
